// ==== rtl/chp_regs.svh ====
`ifndef CHP_REGS_SVH
`define CHP_REGS_SVH

// ==========================================
// Clock and timing
`define CHP_CLK_NS 4
`define CHP_INIT_TIME_NS 1000
`define CHP_INIT_CYCLES ((`CHP_INIT_TIME_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_WE_LOW_NS 80
`define CHP_WE_LOW_CYCLES ((`CHP_WE_LOW_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_STROBE_GAP_NS 32
`define CHP_STROBE_GAP_CYCLES (`CHP_STROBE_GAP_NS / `CHP_CLK_NS)

// ==========================================
// Widths and pin reset values
`define CHP_DATA_W 16
`define CHP_CNT_W 10
`define CHP_FIFO_DEPTH 2
`define CHP_PIN_IDLE 1'b1
`define CHP_VS1_LEVEL 1'b0
`define CHP_VS2_LEVEL 1'b1

`endif

// ==== rtl/chp_pkg.sv ====
package chp_pkg;

	typedef enum logic [1:0] {
		CHP_MODE_MEM,
		CHP_MODE_IO,
		CHP_MODE_DISK
	} chp_mode_t;

	typedef enum logic [1:0] {
		CHP_UDMA_IDLE,
		CHP_UDMA_READ,
		CHP_UDMA_WRITE
	} chp_udma_t;

	typedef enum logic [1:0] {
		CHP_WR_IDLE,
		CHP_WR_STROBE,
		CHP_WR_RECOVER
	} chp_wr_state_t;

endpackage

// ==== rtl/chp_if.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "chp_regs.svh"

interface chp_if;
	// Host to card.
	logic reset_pin;
	logic disk_mode_select_n;
	logic we_n;
	logic oe_n;
	logic attr_n;
	logic [`CHP_DATA_W-1:0] host_data;
	logic host_ready;
	// Card to host.
	logic wait_pin;
	logic wp_pin;
	logic [`CHP_DATA_W-1:0] card_data;
	logic card_data_oe;
	logic voltage_sense_1_n;
	logic voltage_sense_2_n;

	modport card (
		input reset_pin, disk_mode_select_n, we_n, oe_n, attr_n, host_data, host_ready,
		output wait_pin, wp_pin, card_data, card_data_oe, voltage_sense_1_n, voltage_sense_2_n
	);

	modport host (
		output reset_pin, disk_mode_select_n, we_n, oe_n, attr_n, host_data, host_ready,
		input wait_pin, wp_pin, card_data, card_data_oe, voltage_sense_1_n, voltage_sense_2_n
	);
endinterface

`default_nettype wire

// ==== rtl/chp_card.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "chp_regs.svh"

// Function
// - Low reset pin resets card in disk mode.
// - Wait stalls memory cycle in progress.
// - Wait stalls I/O cycle in progress.
// - Disk mode, no UDMA: pin is IORDY.
// - UDMA write: ready pin shows burst acceptance.
// - UDMA read: strobe toggles, host captures both.
// - Memory mode: write strobe writes registers.
// - I/O mode: write strobe writes config only.
// - Disk mode: host holds write strobe high.
// - Memory mode: write protect low after init.
// - I/O mode: port-wide low for 16-bit ports.
// - Disk mode: word-expect low before word cycles.
// - Grounded mode select chooses disk mode.
module chp_card
	import chp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Link
	chp_if.card link,
	// Configuration and status
	input wire logic cfg_io_mode,
	input wire logic busy,
	input wire logic port_wide,
	input wire logic expect_word,
	input var chp_udma_t udma,
	input wire logic udma_wr_ready,
	output logic hw_reset,
	output logic init_done,
	output chp_mode_t mode,
	// Register writes from the host
	output logic wr_valid,
	output logic [`CHP_DATA_W-1:0] wr_data,
	output logic wr_config,
	// UDMA read data
	input wire logic rd_valid,
	output logic rd_ready,
	input wire logic [`CHP_DATA_W-1:0] rd_data
);

	// ==========================================
	// Pin synchronisers
	logic [1:0] sync_rst, sync_sel, sync_we, sync_oe, sync_attr, sync_rdy;
	logic [`CHP_DATA_W-1:0] sync_data_a, sync_data_b;
	logic we_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_rst <= 2'h0;
			sync_sel <= 2'h3;
			sync_we <= 2'h3;
			sync_oe <= 2'h3;
			sync_attr <= 2'h3;
			sync_rdy <= 2'h0;
			sync_data_a <= 16'h0000;
			sync_data_b <= 16'h0000;
			we_prev <= 1'b1;
		end else if (ce) begin
			sync_rst <= {sync_rst[0], link.reset_pin};
			sync_sel <= {sync_sel[0], link.disk_mode_select_n};
			sync_we <= {sync_we[0], link.we_n};
			sync_oe <= {sync_oe[0], link.oe_n};
			sync_attr <= {sync_attr[0], link.attr_n};
			sync_rdy <= {sync_rdy[0], link.host_ready};
			sync_data_a <= link.host_data;
			sync_data_b <= sync_data_a;
			we_prev <= sync_we[1];
		end
	end

	// ==========================================
	// Mode and hardware reset
	chp_mode_t cur_mode;
	logic pin_reset;

	always_comb begin
		if (!sync_sel[1])
			cur_mode = CHP_MODE_DISK;
		else if (cfg_io_mode)
			cur_mode = CHP_MODE_IO;
		else
			cur_mode = CHP_MODE_MEM;
		// Disk mode resets on a low pin; the other modes on a high pin.
		pin_reset = (cur_mode == CHP_MODE_DISK) ? !sync_rst[1] : sync_rst[1];
	end

	assign mode = cur_mode;
	assign hw_reset = pin_reset;

	// ==========================================
	// Reset initialisation sequence
	logic [`CHP_CNT_W-1:0] init_cnt, next_init_cnt;
	logic next_init_done;

	always_comb begin
		next_init_cnt = init_cnt;
		next_init_done = init_done;
		if (pin_reset) begin
			next_init_cnt = '0;
			next_init_done = 1'b0;
		end else if (!init_done) begin
			if (init_cnt == `CHP_CNT_W'(`CHP_INIT_CYCLES - 1))
				next_init_done = 1'b1;
			else
				next_init_cnt = init_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt <= '0;
			init_done <= 1'b0;
		end else if (ce) begin
			init_cnt <= next_init_cnt;
			init_done <= next_init_done;
		end
	end

	// ==========================================
	// Register writes, taken on the trailing edge of the write strobe
	logic we_rise;
	logic next_wr_valid, next_wr_config;
	logic [`CHP_DATA_W-1:0] next_wr_data;

	assign we_rise = sync_we[1] && !we_prev;

	always_comb begin
		next_wr_valid = 1'b0;
		next_wr_data = wr_data;
		next_wr_config = wr_config;
		if (we_rise && !pin_reset) begin
			case (cur_mode)
				CHP_MODE_MEM: begin
					next_wr_valid = 1'b1;
					next_wr_data = sync_data_b;
					next_wr_config = !sync_attr[1];
				end
				CHP_MODE_IO: begin
					next_wr_valid = !sync_attr[1];
					next_wr_data = sync_data_b;
					next_wr_config = 1'b1;
				end
				CHP_MODE_DISK: next_wr_valid = 1'b0;
				default: next_wr_valid = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_valid <= 1'b0;
			wr_data <= 16'h0000;
			wr_config <= 1'b0;
		end else if (ce) begin
			wr_valid <= next_wr_valid;
			wr_data <= next_wr_data;
			wr_config <= next_wr_config;
		end
	end

	// ==========================================
	// Two-entry read buffer
	logic [`CHP_DATA_W-1:0] fifo_mem [`CHP_FIFO_DEPTH];
	logic fifo_wp, fifo_rp, next_fifo_wp, next_fifo_rp;
	logic [1:0] fifo_cnt, next_fifo_cnt;
	logic push, pop;

	assign rd_ready = (fifo_cnt != 2'h2) && !pin_reset;
	assign push = rd_valid && rd_ready;

	always_comb begin
		next_fifo_wp = fifo_wp;
		next_fifo_rp = fifo_rp;
		next_fifo_cnt = fifo_cnt;
		if (pin_reset) begin
			next_fifo_wp = 1'b0;
			next_fifo_rp = 1'b0;
			next_fifo_cnt = 2'h0;
		end else begin
			if (push)
				next_fifo_wp = !fifo_wp;
			if (pop)
				next_fifo_rp = !fifo_rp;
			if (push && !pop)
				next_fifo_cnt = fifo_cnt + 2'h1;
			else if (pop && !push)
				next_fifo_cnt = fifo_cnt - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_wp <= 1'b0;
			fifo_rp <= 1'b0;
			fifo_cnt <= 2'h0;
		end else if (ce) begin
			fifo_wp <= next_fifo_wp;
			fifo_rp <= next_fifo_rp;
			fifo_cnt <= next_fifo_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && push)
			fifo_mem[fifo_wp] <= rd_data;
	end

	// ==========================================
	// UDMA read sender: data is set up two cycles before each strobe edge on the wait pin
	logic [`CHP_DATA_W-1:0] next_cdata;
	logic [3:0] gap, next_gap;
	logic strobe, next_strobe, pend, next_pend;
	logic rd_active;

	assign rd_active = (cur_mode == CHP_MODE_DISK) && (udma == CHP_UDMA_READ);
	assign pop = rd_active && !pin_reset && (gap == 4'h0) && (fifo_cnt != 2'h0) && sync_rdy[1];

	always_comb begin
		next_cdata = link.card_data;
		next_gap = gap;
		next_strobe = strobe;
		next_pend = 1'b0;
		if (!rd_active || pin_reset) begin
			next_gap = 4'h0;
			next_strobe = 1'b0;
		end else if (pop) begin
			next_cdata = fifo_mem[fifo_rp];
			next_gap = 4'(`CHP_STROBE_GAP_CYCLES);
			next_pend = 1'b1;
		end else if (gap != 4'h0) begin
			next_gap = gap - 4'h1;
		end
		if (pend)
			next_strobe = !strobe;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.card_data <= 16'h0000;
			gap <= 4'h0;
			strobe <= 1'b0;
			pend <= 1'b0;
		end else if (ce) begin
			link.card_data <= next_cdata;
			gap <= next_gap;
			strobe <= next_strobe;
			pend <= next_pend;
		end
	end

	// ==========================================
	// Shared output pins
	logic next_wait, next_wp, cycle_active;

	assign cycle_active = !sync_we[1] || !sync_oe[1];

	always_comb begin
		next_wait = `CHP_PIN_IDLE;
		next_wp = `CHP_PIN_IDLE;
		case (cur_mode)
			CHP_MODE_MEM: begin
				next_wait = !(cycle_active && (busy || !init_done));
				next_wp = !init_done;
			end
			CHP_MODE_IO: begin
				next_wait = !(cycle_active && (busy || !init_done));
				next_wp = !port_wide;
			end
			CHP_MODE_DISK: begin
				next_wp = !expect_word;
				case (udma)
					CHP_UDMA_READ: next_wait = strobe;
					CHP_UDMA_WRITE: next_wait = !udma_wr_ready;
					default: next_wait = !(busy || !init_done);
				endcase
			end
			default: next_wait = `CHP_PIN_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.wait_pin <= `CHP_PIN_IDLE;
			link.wp_pin <= `CHP_PIN_IDLE;
			link.card_data_oe <= 1'b0;
		end else if (ce) begin
			link.wait_pin <= next_wait;
			link.wp_pin <= next_wp;
			link.card_data_oe <= rd_active && !pin_reset;
		end
	end

	assign link.voltage_sense_1_n = `CHP_VS1_LEVEL;
	assign link.voltage_sense_2_n = `CHP_VS2_LEVEL;

endmodule

`default_nettype wire

// ==== rtl/chp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "chp_regs.svh"

module chp_host
	import chp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Link
	chp_if.host link,
	// Control
	input wire logic disk_mode,
	input wire logic reset_req,
	// Register write requests
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [`CHP_DATA_W-1:0] wr_data,
	input wire logic wr_config,
	// UDMA read data
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [`CHP_DATA_W-1:0] rd_data,
	// Card status
	output logic card_ready,
	output logic card_wp
);

	// ==========================================
	// Pin synchronisers
	logic [1:0] sync_wait, sync_wp, sync_oe;
	logic [`CHP_DATA_W-1:0] sync_data_a, sync_data_b;
	logic strobe_prev, oe_prev;

	// The edge detectors start at the idle levels of their pins, so no false edge follows reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_wait <= 2'h3;
			sync_wp <= 2'h3;
			sync_oe <= 2'h0;
			sync_data_a <= 16'h0000;
			sync_data_b <= 16'h0000;
			strobe_prev <= 1'b1;
			oe_prev <= 1'b0;
		end else if (ce) begin
			sync_wait <= {sync_wait[0], link.wait_pin};
			sync_wp <= {sync_wp[0], link.wp_pin};
			sync_oe <= {sync_oe[0], link.card_data_oe};
			sync_data_a <= link.card_data;
			sync_data_b <= sync_data_a;
			strobe_prev <= sync_wait[1];
			oe_prev <= sync_oe[1];
		end
	end

	assign card_ready = sync_wait[1];
	assign card_wp = sync_wp[1];

	// ==========================================
	// Static pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.disk_mode_select_n <= 1'b1;
			link.reset_pin <= 1'b0;
		end else if (ce) begin
			link.disk_mode_select_n <= !disk_mode;
			link.reset_pin <= disk_mode ? !reset_req : reset_req;
		end
	end

	assign link.oe_n = 1'b1;

	// ==========================================
	// Write strobe cycles, stretched while the card holds wait low
	chp_wr_state_t state, next_state;
	logic [`CHP_CNT_W-1:0] cnt, next_cnt;
	logic [`CHP_DATA_W-1:0] next_hdata;
	logic next_attr_n;

	assign wr_ready = (state == CHP_WR_IDLE) && !disk_mode;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_hdata = link.host_data;
		next_attr_n = link.attr_n;
		case (state)
			CHP_WR_IDLE: begin
				if (wr_valid && wr_ready) begin
					next_state = CHP_WR_STROBE;
					next_hdata = wr_data;
					next_attr_n = !wr_config;
					next_cnt = '0;
				end
			end
			CHP_WR_STROBE: begin
				if (cnt < `CHP_CNT_W'(`CHP_WE_LOW_CYCLES - 1))
					next_cnt = cnt + 1'b1;
				else if (sync_wait[1])
					next_state = CHP_WR_RECOVER;
			end
			CHP_WR_RECOVER: begin
				next_state = CHP_WR_IDLE;
				next_attr_n = 1'b1;
			end
			default: next_state = CHP_WR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CHP_WR_IDLE;
			cnt <= '0;
			link.host_data <= 16'h0000;
			link.attr_n <= 1'b1;
			link.we_n <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			link.host_data <= next_hdata;
			link.attr_n <= next_attr_n;
			link.we_n <= !(next_state == CHP_WR_STROBE) || disk_mode;
		end
	end

	// ==========================================
	// UDMA read capture on both strobe edges
	logic next_rd_valid;
	logic [`CHP_DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_valid = rd_valid && !rd_ready;
		next_rd_data = rd_data;
		// Only strobe edges seen while the card has driven data for a whole cycle carry words;
		// the same pin means ready or busy outside a read burst.
		if (disk_mode && sync_oe[1] && oe_prev && (sync_wait[1] != strobe_prev)) begin
			next_rd_valid = 1'b1;
			next_rd_data = sync_data_b;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
			link.host_ready <= 1'b0;
		end else if (ce) begin
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			link.host_ready <= !next_rd_valid;
		end
	end

endmodule

`default_nettype wire

// ==== tb/chp_pin_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "chp_regs.svh"

// ==========================================
// Checks on the wires between the two ends.
module chp_pin_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic disk_mode_select_n,
	input wire logic we_n,
	input wire logic attr_n,
	input wire logic [`CHP_DATA_W-1:0] host_data,
	input wire logic wait_pin,
	input wire logic [`CHP_DATA_W-1:0] card_data,
	input wire logic card_data_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_we_low20;
		!we_n [*8] ##1 !we_n [*8] ##1 !we_n [*4];
	endsequence
	sequence s_strobe_quiet;
		(!card_data_oe || !$changed(wait_pin)) [*7];
	endsequence
	sequence s_wait_low;
		!wait_pin [*4];
	endsequence

	a_we_low_time: assert property ($fell(we_n) |-> s_we_low20)
		else $error("write strobe shorter than 20 cycles");
	a_we_data_hold: assert property (!we_n && !$past(we_n) |-> $stable(host_data))
		else $error("write data moved under the strobe");
	a_wait_holds_we: assert property (s_wait_low ##0 !we_n |=> !we_n)
		else $error("write strobe ended while wait was low");
	a_we_recover: assert property ($rose(we_n) |=> attr_n)
		else $error("config select not released after strobe");
	a_disk_we_high: assert property (!disk_mode_select_n |-> we_n)
		else $error("write strobe pulsed in disk mode");
	a_oe_disk_only: assert property (card_data_oe |-> !disk_mode_select_n)
		else $error("card drives data outside disk mode");
	a_data_then_strobe: assert property (card_data_oe && $changed(card_data) |-> ##2 $changed(wait_pin))
		else $error("no strobe edge after a new read word");
	a_strobe_gap: assert property (card_data_oe && $past(card_data_oe) && $changed(wait_pin) |=> s_strobe_quiet)
		else $error("strobe edges closer than 8 cycles");
endmodule

`default_nettype wire

// ==== tb/card_host_pin_signalling_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module card_host_pin_signalling_tb;
	import chp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic io_mode = 1'b0, busy = 1'b0, port_wide = 1'b0, expect_word = 1'b0, wr_rdy = 1'b0;
	logic c_rd_valid = 1'b0, disk = 1'b0, reset_req = 1'b0;
	logic h_wr_valid = 1'b0, h_wr_config = 1'b0, h_rd_ready = 1'b0;
	logic [15:0] c_rd_data = 16'h0, h_wr_data = 16'h0;
	chp_udma_t udma = CHP_UDMA_IDLE;
	logic hw_reset, init_done, c_wr_valid, c_wr_config, c_rd_ready;
	logic h_wr_ready, h_rd_valid, card_ready, card_wp;
	logic [15:0] c_wr_data, h_rd_data;
	chp_mode_t mode;
	int bad_count = 0, checks = 0, cycles = 0;
	logic [16:0] wq[$], rq[$];

	chp_if link();
	chp_card i_chp_card(.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .cfg_io_mode(io_mode),
		.busy(busy), .port_wide(port_wide), .expect_word(expect_word), .udma(udma),
		.udma_wr_ready(wr_rdy), .hw_reset(hw_reset), .init_done(init_done), .mode(mode),
		.wr_valid(c_wr_valid), .wr_data(c_wr_data), .wr_config(c_wr_config),
		.rd_valid(c_rd_valid), .rd_ready(c_rd_ready), .rd_data(c_rd_data));
	chp_host i_chp_host(.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .disk_mode(disk),
		.reset_req(reset_req), .wr_valid(h_wr_valid), .wr_ready(h_wr_ready), .wr_data(h_wr_data),
		.wr_config(h_wr_config), .rd_valid(h_rd_valid), .rd_ready(h_rd_ready),
		.rd_data(h_rd_data), .card_ready(card_ready), .card_wp(card_wp));
	chp_pin_sva i_chp_pin_sva(.clk(clk), .rst_n(rst_n),
		.disk_mode_select_n(link.disk_mode_select_n), .we_n(link.we_n), .attr_n(link.attr_n),
		.host_data(link.host_data), .wait_pin(link.wait_pin), .card_data(link.card_data),
		.card_data_oe(link.card_data_oe));

	always #2 clk = ~clk;

	// ==========================================
	// Comparison, closing report and watchers.
	task chk(input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wait_init;
		for (int i = 0; i < 400 && init_done !== 1'b1; i++) step(1);
		chk(init_done, 1);
	endtask

	task wr(input logic cfg, input logic exp);
		logic [15:0] d;
		d = 16'($urandom);
		h_wr_data = d;
		h_wr_config = cfg;
		h_wr_valid = 1'b1;
		do @(posedge clk); while (h_wr_ready !== 1'b1);
		#1 h_wr_valid = 1'b0;
		if (exp) wq.push_back({cfg, d});
		step(60);
	endtask

	always @(posedge clk) begin
		if (c_wr_valid === 1'b1) chk({c_wr_config, c_wr_data}, wq.size() ? wq.pop_front() : 17'bx);
		if (h_rd_valid === 1'b1 && h_rd_ready === 1'b1) chk({1'b0, h_rd_data}, rq.size() ? rq.pop_front() : 17'bx);
	end

	// The host stalls at random so that the read buffer fills.
	always @(posedge clk) #1 h_rd_ready = 1'($urandom);

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ==========================================
	// Main sequence.
	initial begin
		void'($urandom(32'hc5ea));
		step(5);
		rst_n = 1'b1;
		chk(link.wp_pin, 1);
		wait_init;
		step(6);
		chk(link.wp_pin, 0);
		chk(card_wp, 0);
		chk(mode, CHP_MODE_MEM);
		busy = 1'b1;
		fork
			wr(1'b0, 1'b1);
			begin
				step(30);
				chk(link.we_n, 0);
				busy = 1'b0;
			end
		join
		repeat (3) wr(1'($urandom), 1'b1);
		io_mode = 1'b1;
		step(8);
		chk(mode, CHP_MODE_IO);
		busy = 1'b1;
		fork
			wr(1'b1, 1'b1);
			begin
				step(30);
				chk(link.we_n, 0);
				busy = 1'b0;
			end
		join
		wr(1'b0, 1'b0);
		for (int i = 0; i < 2; i++) begin
			port_wide = i[0];
			step(6);
			chk(link.wp_pin, !port_wide);
		end
		disk = 1'b1;
		step(8);
		wait_init;
		chk(mode, CHP_MODE_DISK);
		chk(h_wr_ready, 0);
		for (int i = 0; i < 4; i++) begin
			{busy, expect_word} = 2'(i);
			step(6);
			chk({link.wait_pin, link.wp_pin}, {!busy, !expect_word});
			chk({card_ready, card_wp}, {!busy, !expect_word});
		end
		{busy, expect_word} = 2'b00;
		udma = CHP_UDMA_WRITE;
		for (int i = 0; i < 2; i++) begin
			wr_rdy = i[0];
			step(6);
			chk(link.wait_pin, !wr_rdy);
		end
		udma = CHP_UDMA_READ;
		step(6);
		chk(link.card_data_oe, 1);
		for (int i = 0; i < 6; i++) begin
			c_rd_data = 16'($urandom);
			c_rd_valid = 1'b1;
			do @(posedge clk); while (c_rd_ready !== 1'b1);
			rq.push_back({1'b0, c_rd_data});
			#1;
		end
		c_rd_valid = 1'b0;
		for (int i = 0; i < 500 && rq.size() > 0; i++) step(1);
		chk(17'(rq.size()), 0);
		udma = CHP_UDMA_IDLE;
		step(8);
		reset_req = 1'b1;
		step(8);
		chk({hw_reset, init_done, link.reset_pin}, 3'b100);
		reset_req = 1'b0;
		step(8);
		wait_init;
		give_verdict();
	end
endmodule

`default_nettype wire
